// ==== tb/pfr_fault_ctrl_props.sv ====
// checker: port-level assertions for pfr_fault_ctrl
// assumes: bound into pfr_fault_ctrl, detect pins move with core_clk
module pfr_fault_ctrl_props (
	input wire logic core_clk, // clock
	input wire logic resetn, // reset
	input wire logic output_undervolt_detect, // pin
	input wire logic peak_overcurrent_protect, // pin
	input wire logic clear_faults, // clear
	input wire logic store_user_all, // store
	input wire logic output_enable, // stage on
	input wire logic current_limit_on, // limiting
	input wire logic alert_out_n, // alert
	input wire logic status_word_vout, // status
	input wire logic status_vout_undervolt, // status
	input wire logic status_word_iout, // status
	input wire logic status_byte_iout, // status
	input wire logic status_iout_peak, // status
	input wire logic status_cml_invalid, // status
	input wire logic nv_wr_en // store pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// ====================
	// fault reporting
	chk_uv_report: assert property (
		output_undervolt_detect [*3] |=> status_word_vout && status_vout_undervolt)
		else $error("uv not flagged");
	chk_oc_report: assert property (
		peak_overcurrent_protect [*3] |=> status_word_iout && status_byte_iout && status_iout_peak)
		else $error("oc not flagged");
	chk_alert_low: assert property (
		status_word_vout || status_word_iout || status_cml_invalid |-> ##[0:1] !alert_out_n)
		else $error("alert missing");
	// ====================
	// stickiness and side effects
	chk_uv_sticky: assert property (
		status_vout_undervolt && !clear_faults |=> status_vout_undervolt && status_word_vout)
		else $error("uv status lost");
	chk_oc_sticky: assert property (
		status_iout_peak && !clear_faults |=> status_iout_peak && status_byte_iout)
		else $error("oc status lost");
	chk_inv_sticky: assert property (
		status_cml_invalid && !clear_faults |=> status_cml_invalid)
		else $error("invalid flag lost");
	chk_store_pulse: assert property (
		store_user_all |=> nv_wr_en ##1 !nv_wr_en)
		else $error("store pulse wrong");
	chk_limit_run: assert property (
		$rose(current_limit_on) |-> output_enable && $past(peak_overcurrent_protect, 3))
		else $error("limit while stopped");
	cover property ($rose(status_iout_peak));
	cover property ($fell(output_enable));
	cover property ($rose(status_cml_invalid));
	cover property ($rose(nv_wr_en));
endmodule : pfr_fault_ctrl_props

bind pfr_fault_ctrl pfr_fault_ctrl_props pfr_fault_ctrl_props_i (
	.core_clk, .resetn, .output_undervolt_detect, .peak_overcurrent_protect,
	.clear_faults, .store_user_all, .output_enable, .current_limit_on, .alert_out_n,
	.status_word_vout, .status_vout_undervolt, .status_word_iout, .status_byte_iout,
	.status_iout_peak, .status_cml_invalid, .nv_wr_en
);

// ==== tb/pfr_fault_ctrl_tb.sv ====
// bench: drives pfr_fault_ctrl through its link and fault pins
// assumes: short timers (base 4, hiccup 20); pfr_host_model makes transfers
module pfr_fault_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pfr_pkg::*;
	logic core_clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, link_resetn = 1'b0;
	logic uv = 1'b0, oc = 1'b0, pon = 1'b0, clr = 1'b0, sto = 1'b0;
	logic host_valid, host_write, host_ready, host_rsp_valid, output_enable;
	logic current_limit_on, alert_out_n, status_word_vout, status_vout_undervolt;
	logic status_word_iout, status_byte_iout, status_iout_peak, status_cml_invalid, nv_wr_en;
	logic [CODE_W-1:0] host_code;
	logic [DATA_W-1:0] host_wdata, host_rsp_data, rd;
	logic [7:0] nv_uv_action, nv_oc_action;
	logic [15:0] nv_oc_limit, st;
	logic [15:0] shadow [3];
	logic [15:0] act [2] = '{16'h0000, 16'h0040};
	// {accepted, code, word}
	logic [24:0] tbl [16] = '{25'h1460801, 25'h0460800, 25'h0460820, 25'h046101B,
		25'h146081F, 25'h046001F, 25'h1450000, 25'h145007F, 25'h0450080, 25'h04500C0,
		25'h0450048, 25'h0450070, 25'h14700C0, 25'h0470088, 25'h14700F8, 25'h1470040};
	int n_mismatch = 0;
	int checks = 0;
	int k;
	bit ok;
	// invalid, enable, limit, alert_n, word vout, vout undervolt, word iout, byte iout, iout peak
	assign st = {7'h00, status_cml_invalid, output_enable, current_limit_on, alert_out_n,
		status_word_vout, status_vout_undervolt, status_word_iout, status_byte_iout, status_iout_peak};
	pfr_fault_ctrl #(.OC_BASE_CYC(TMR_W'(4)), .HICCUP_CYC(TMR_W'(20))) pfr_fault_ctrl_i (
		.core_clk, .resetn, .link_clk, .link_resetn, .host_valid, .host_write, .host_code,
		.host_wdata, .host_ready, .host_rsp_valid, .host_rsp_data,
		.output_undervolt_detect(uv), .peak_overcurrent_protect(oc), .power_on_cmd(pon),
		.clear_faults(clr), .store_user_all(sto), .output_enable, .current_limit_on,
		.alert_out_n, .status_word_vout, .status_vout_undervolt, .status_word_iout,
		.status_byte_iout, .status_iout_peak, .status_cml_invalid, .nv_wr_en,
		.nv_uv_action, .nv_oc_limit, .nv_oc_action
	);
	pfr_host_model pfr_host_model_i (
		.link_clk, .host_valid, .host_write, .host_code, .host_wdata, .host_ready,
		.host_rsp_valid, .host_rsp_data
	);
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	// offset keeps link edges clear of core edges
	initial begin
		#7;
		forever #24 link_clk = ~link_clk;
	end
	// ====================
	// tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up
	task automatic acc(input int gap, input logic w, input logic [7:0] c, input logic [15:0] d);
		pfr_host_model_i.xfer(gap, w, c, d, rd, ok);
		// realign to a core edge so pins and strobes move with core_clk
		cyc(1);
		if (!ok) begin
			n_mismatch++;
			$display("wrong value link answer expected 1 seen 0");
			wrap_up();
		end
	endtask : acc
	task automatic clear();
		clr <= 1'b1;
		cyc(1);
		clr <= 1'b0;
		cyc(3);
		chk("cleared", 16'h00A0, st);
	endtask : clear
	task automatic step(input logic u, input logic o, input int n, input logic [15:0] exp);
		uv <= u;
		oc <= o;
		cyc(n);
		chk("status", exp, st);
	endtask : step
	task automatic readall();
		for (int j = 0; j < 3; j++) begin
			acc(j, 1'b0, CMD_UV_ACTION + 8'(j), 16'h0000);
			chk("readback", shadow[j], rd);
		end
	endtask : readall
	// ====================
	// sequence
	initial begin
		shadow = '{16'h0040, 16'h081B, 16'h0080};
		cyc(8);
		resetn <= 1'b1;
		link_resetn <= 1'b1;
		cyc(3);
		chk("reset state", 16'h0020, st);
		readall();
		pon <= 1'b1;
		cyc(3);
		foreach (tbl[i]) begin
			k = int'(tbl[i][23:16]) - 'h45;
			acc(i % 2 * 3, 1'b1, tbl[i][23:16], tbl[i][15:0]);
			shadow[k] = tbl[i][24] ? tbl[i][15:0] : shadow[k];
			chk("answer", shadow[k], rd);
			cyc(6);
			chk("invalid", tbl[i][24] ? 16'h00A0 : 16'h0180, st);
			clear();
		end
		readall();
		acc(0, 1'b1, 8'h48, 16'h1234);
		acc(0, 1'b0, 8'h48, 16'h0000);
		chk("unmapped", 16'h0000, rd);
		sto <= 1'b1;
		cyc(1);
		sto <= 1'b0;
		cyc(2);
		chk("nv bytes", {shadow[0][7:0], shadow[2][7:0]}, {nv_uv_action, nv_oc_action});
		chk("nv limit", shadow[1], nv_oc_limit);
		acc(0, 1'b1, CMD_UV_ACTION, 16'h0000);
		step(1'b1, 1'b0, 8, 16'h0098);
		step(1'b0, 1'b0, 8, 16'h0098);
		clear();
		acc(0, 1'b1, CMD_UV_ACTION, 16'h0043);
		step(1'b1, 1'b0, 400, 16'h0098);
		step(1'b0, 1'b0, 5, 16'h0098);
		clear();
		acc(0, 1'b1, CMD_UV_ACTION, 16'h0044);
		step(1'b1, 1'b0, 300, 16'h0098);
		step(1'b1, 1'b0, 30, 16'h0018);
		step(1'b0, 1'b0, 5, 16'h0018);
		clear();
		acc(0, 1'b1, CMD_UV_ACTION, 16'h0078);
		step(1'b1, 1'b0, 330, 16'h0018);
		step(1'b0, 1'b0, 30, 16'h0098);
		clear();
		acc(0, 1'b1, CMD_OC_ACTION, 16'h00C0);
		step(1'b0, 1'b1, 5, 16'h0007);
		step(1'b0, 1'b0, 5, 16'h0007);
		clear();
		acc(0, 1'b1, CMD_OC_ACTION, 16'h00F8);
		step(1'b0, 1'b1, 6, 16'h0007);
		step(1'b0, 1'b0, 25, 16'h0087);
		clear();
		acc(3, 1'b1, CMD_OC_ACTION, 16'h0083);
		step(1'b0, 1'b1, 20, 16'h00C7);
		step(1'b0, 1'b1, 20, 16'h0007);
		step(1'b0, 1'b0, 5, 16'h0007);
		clear();
		foreach (act[j]) begin
			acc(0, 1'b1, CMD_OC_ACTION, act[j]);
			step(1'b0, 1'b1, 80, 16'h00C7);
			step(1'b0, 1'b0, 5, 16'h0087);
			clear();
		end
		wrap_up();
	end
endmodule : pfr_fault_ctrl_tb

// ==== tb/pfr_host_model.sv ====
// host model: one command transfer at a time on the link
// assumes: link_clk free running, answers within 20 link cycles
module pfr_host_model (
	input wire logic link_clk, // clock
	output logic host_valid = 1'b0, // request
	output logic host_write = 1'b0, // kind
	output logic [pfr_pkg::CODE_W-1:0] host_code = '0, // code
	output logic [pfr_pkg::DATA_W-1:0] host_wdata = '0, // data
	input wire logic host_ready, // idle
	input wire logic host_rsp_valid, // answer
	input wire logic [pfr_pkg::DATA_W-1:0] host_rsp_data // word
);
	timeunit 1ns;
	timeprecision 1ns;
	import pfr_pkg::*;
	// ====================
	// transfer
	task automatic xfer(input int gap, input logic w, input logic [CODE_W-1:0] c,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd, output bit ok);
		ok = 1'b0;
		rd = '0;
		repeat (gap + 1) @(posedge link_clk);
		host_valid <= 1'b1;
		host_write <= w;
		host_code <= c;
		host_wdata <= d;
		for (int n = 0; n < 20 && !ok; n++) begin
			@(posedge link_clk);
			ok = host_ready === 1'b1;
		end
		// released lines carry junk so a stale word is never mistaken for live
		host_valid <= 1'b0;
		host_write <= ~w;
		host_code <= ~c;
		host_wdata <= ~d;
		if (ok) begin
			ok = 1'b0;
			for (int n = 0; n < 20 && !ok; n++) begin
				@(posedge link_clk);
				ok = host_rsp_valid === 1'b1;
			end
			rd = host_rsp_data;
		end
	endtask : xfer
endmodule : pfr_host_model

// ==== verilog/pfr_delay_timer.sv ====
// pfr_delay_timer: counts while run is high, flags when limit is reached
// assumes: core clock domain; dropping run cancels and clears the count
module pfr_delay_timer (
	input wire logic core_clk, // core clock
	input wire logic resetn, // sync reset, active low
	input wire logic run, // count while high
	input wire logic [pfr_pkg::TMR_W-1:0] limit, // cycles to expiry
	output logic expired // high from expiry until run drops
);
	import pfr_pkg::*;

	typedef struct packed {
		logic [TMR_W-1:0] count;
		logic done;
	} pfr_tmr_t;

	pfr_tmr_t st_reg;
	pfr_tmr_t st_next;

	always_comb begin
		st_next = st_reg;
		if (!run) begin
			st_next = '0;
		end else if (!st_reg.done) begin
			if (st_reg.count >= limit - 1'b1) begin
				st_next.done = 1'b1;
			end else begin
				st_next.count = st_reg.count + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign expired = st_reg.done;

endmodule : pfr_delay_timer

// ==== verilog/pfr_fault_ctrl.sv ====
// pfr_fault_ctrl: fault response registers, sticky status and power-state control
// assumes: detect pins are asynchronous; host commands arrive on link_clk;
// power_on_cmd, clear_faults and store_user_all come from core_clk logic
// Behaviour
// [R1] undervoltage detect sets status-word vout, status-vout undervolt bit, alert
// [R2] fault status bits are sticky; only clear_faults clears them
// [R3] reset values: undervolt action 40h, overcurrent action 80h, latch-off
// [R4] undervolt bits 7:6: 00 ignore, 01 delay then retry, 10/11 unsupported
// [R5] retry 000 latch off until cleared, 111 hiccup with 1 s period
// [R6] undervolt delay bits 1:0 pick 6.25/7.5/8.75/10 us, bit 2 ignored
// [R7] unsupported response encoding written raises invalid-data fault
// [R8] trip level is LINEAR11: 5-bit exponent, 11-bit mantissa, peak current
// [R9] trip level exponent fixed at 1; other exponent raises invalid data
// [R10] only words 0801..081F accepted, reset 081B, else invalid data
// [R11] peak overcurrent sets iout in status word and byte, iout bit 7, alert
// [R12] overcurrent action 00: keep running in current limit
// [R13] overcurrent action 01: keep running unless undervoltage acts
// [R14] overcurrent action 10: limit for delay, then apply retry
// [R15] overcurrent action 11: shut down at once, then apply retry
// [R16] overcurrent delay field selects windows from 160 us to 10.08 ms
// [R17] store_user_all copies the three registers to nonvolatile store
// [R18] delay timer starts at detection, cancelled if fault clears first
// [R19] host reads status on alert, then clears faults
module pfr_fault_ctrl #(
	parameter logic [pfr_pkg::TMR_W-1:0] OC_BASE_CYC = pfr_pkg::OC_BASE_CYC_DFLT, // 160 us
	parameter logic [pfr_pkg::TMR_W-1:0] HICCUP_CYC = pfr_pkg::HICCUP_CYC_DFLT // 1 s
) (
	input wire logic core_clk, // core clock
	input wire logic resetn, // sync reset, active low
	input wire logic link_clk, // host link clock
	input wire logic link_resetn, // link reset, active low
	input wire logic host_valid, // host request present
	input wire logic host_write, // 1 write, 0 read
	input wire logic [pfr_pkg::CODE_W-1:0] host_code, // command code
	input wire logic [pfr_pkg::DATA_W-1:0] host_wdata, // write data
	output logic host_ready, // link port idle
	output logic host_rsp_valid, // answer pulse
	output logic [pfr_pkg::DATA_W-1:0] host_rsp_data, // readback word
	input wire logic output_undervolt_detect, // async undervolt comparator
	input wire logic peak_overcurrent_protect, // async peak current comparator
	input wire logic power_on_cmd, // output commanded on
	input wire logic clear_faults, // clear sticky faults pulse
	input wire logic store_user_all, // store command pulse
	output logic output_enable, // power stage enabled
	output logic current_limit_on, // stage held in current limit
	output logic alert_out_n, // alert, active low
	output logic status_word_vout, // status word vout bit
	output logic status_vout_undervolt, // status vout undervolt fault
	output logic status_word_iout, // status word iout bit
	output logic status_byte_iout, // status byte iout bit
	output logic status_iout_peak, // status iout bit 7
	output logic status_cml_invalid, // invalid data fault
	output logic nv_wr_en, // nonvolatile write pulse
	output logic [7:0] nv_uv_action, // stored undervolt action
	output logic [15:0] nv_oc_limit, // stored trip level
	output logic [7:0] nv_oc_action // stored overcurrent action
);
	import pfr_pkg::*;

	// ===========================================
	// state
	typedef struct packed {
		pfr_pwr_t pwr;
		logic [7:0] uv_act;
		logic [15:0] oc_lim;
		logic [7:0] oc_act;
		logic uv_meta;
		logic uv_s;
		logic oc_meta;
		logic oc_s;
		logic req_meta;
		logic req_s;
		logic req_seen;
		logic ack_tgl;
		logic [DATA_W-1:0] rsp_data;
		logic sts_word_vout;
		logic sts_vout_low;
		logic sts_word_iout;
		logic sts_byte_iout;
		logic sts_iout_peak;
		logic sts_cml;
		logic alert_n;
		logic ilim;
		logic nv_wr;
		logic [7:0] nv_uv;
		logic [15:0] nv_lim;
		logic [7:0] nv_oc;
	} pfr_core_t;

	localparam pfr_core_t CORE_RST = '{
		pwr: PWR_OFF,
		uv_act: RST_UV_ACTION, // R3
		oc_lim: RST_OC_LIMIT, // R10
		oc_act: RST_OC_ACTION, // R3
		alert_n: 1'b1,
		default: '0
	};

	pfr_core_t st_reg;
	pfr_core_t st_next;

	logic xfer_req_tgl;
	logic xfer_write;
	logic [CODE_W-1:0] xfer_code;
	logic [DATA_W-1:0] xfer_wdata;
	logic [TMR_W-1:0] uv_dly;
	logic [5:0] oc_mult;
	logic [TMR_W-1:0] oc_dly;
	logic uv_run;
	logic oc_run;
	logic hic_run;
	logic uv_exp;
	logic oc_exp;
	logic hic_exp;
	logic uv_trip;
	logic oc_trip;
	logic bad;
	logic [1:0] oc_code;

	// ===========================================
	// write checks
	function automatic logic retry_ok(input logic [2:0] r);
		return (r == RETRY_LATCH) || (r == RETRY_HICCUP); // R5
	endfunction : retry_ok

	function automatic logic uv_act_ok(input logic [7:0] v);
		logic [1:0] a;
		a = v[ACT_LSB +: 2];
		return (a == UV_ACT_IGNORE || a == UV_ACT_DELAY) && retry_ok(v[RETRY_LSB +: 3]); // R4
	endfunction : uv_act_ok

	function automatic logic lim_ok(input logic [15:0] v);
		logic [10:0] m;
		m = v[10:0];
		return (v[LIM_EXP_LSB +: 5] == LIM_EXP) // R9
			&& (m >= LIM_MANT_MIN) && (m <= LIM_MANT_MAX); // R10
	endfunction : lim_ok

	// ===========================================
	// host port on the link clock
	pfr_link_port u_link (
		.link_clk(link_clk),
		.link_resetn(link_resetn),
		.host_valid(host_valid),
		.host_write(host_write),
		.host_code(host_code),
		.host_wdata(host_wdata),
		.host_ready(host_ready),
		.host_rsp_valid(host_rsp_valid),
		.host_rsp_data(host_rsp_data),
		.xfer_req_tgl(xfer_req_tgl),
		.xfer_write(xfer_write),
		.xfer_code(xfer_code),
		.xfer_wdata(xfer_wdata),
		.xfer_ack_tgl(st_reg.ack_tgl),
		.xfer_rsp_data(st_reg.rsp_data)
	);

	// ===========================================
	// delay selection
	always_comb begin
		unique case (st_reg.uv_act[UV_DLY_LSB +: 2]) // R6
			2'h0: uv_dly = UV_DLY0_CYC;
			2'h1: uv_dly = UV_DLY1_CYC;
			2'h2: uv_dly = UV_DLY2_CYC;
			2'h3: uv_dly = UV_DLY3_CYC;
		endcase
		unique case (st_reg.oc_act[OC_DLY_LSB +: 3]) // R16
			3'h0: oc_mult = OC_MULT0;
			3'h1: oc_mult = OC_MULT1;
			3'h2: oc_mult = OC_MULT2;
			3'h3: oc_mult = OC_MULT3;
			3'h4: oc_mult = OC_MULT4;
			3'h5: oc_mult = OC_MULT5;
			3'h6: oc_mult = OC_MULT6;
			3'h7: oc_mult = OC_MULT7;
		endcase
	end

	// window lower edge used; step count is a parameter so sims can shrink it
	assign oc_dly = OC_BASE_CYC * TMR_W'(oc_mult); // R16
	assign oc_code = st_reg.oc_act[ACT_LSB +: 2];

	// uv and oc timers only run while the fault is present in RUN; hiccup timer runs in HICCUP
	assign uv_run = (st_reg.pwr == PWR_RUN) && st_reg.uv_s
		&& (st_reg.uv_act[ACT_LSB +: 2] == UV_ACT_DELAY); // R18
	assign oc_run = (st_reg.pwr == PWR_RUN) && st_reg.oc_s
		&& (oc_code == OC_ACT_DELAY); // R18
	assign hic_run = (st_reg.pwr == PWR_HICCUP);

	pfr_delay_timer u_uv_tmr (
		.core_clk(core_clk),
		.resetn(resetn),
		.run(uv_run),
		.limit(uv_dly),
		.expired(uv_exp)
	);

	pfr_delay_timer u_oc_tmr (
		.core_clk(core_clk),
		.resetn(resetn),
		.run(oc_run),
		.limit(oc_dly),
		.expired(oc_exp)
	);

	pfr_delay_timer u_hic_tmr (
		.core_clk(core_clk),
		.resetn(resetn),
		.run(hic_run),
		.limit(HICCUP_CYC),
		.expired(hic_exp)
	);

	assign uv_trip = uv_run && uv_exp; // R4
	// codes 00 and 01 never trip here; 01 leaves shutdown to undervolt
	assign oc_trip = (st_reg.pwr == PWR_RUN) && st_reg.oc_s
		&& ((oc_code == OC_ACT_SHUT) || (oc_run && oc_exp)); // R13 R14 R15

	// ===========================================
	// next state
	always_comb begin
		st_next = st_reg;
		bad = 1'b0;
		st_next.uv_meta = output_undervolt_detect;
		st_next.uv_s = st_reg.uv_meta;
		st_next.oc_meta = peak_overcurrent_protect;
		st_next.oc_s = st_reg.oc_meta;
		st_next.req_meta = xfer_req_tgl;
		st_next.req_s = st_reg.req_meta;
		st_next.nv_wr = 1'b0;

		// sticky status: a detection in the clear cycle still sets
		st_next.sts_word_vout = (st_reg.sts_word_vout & ~clear_faults) | st_reg.uv_s; // R1 R2
		st_next.sts_vout_low = (st_reg.sts_vout_low & ~clear_faults) | st_reg.uv_s; // R1 R2
		st_next.sts_word_iout = (st_reg.sts_word_iout & ~clear_faults) | st_reg.oc_s; // R11 R2
		st_next.sts_byte_iout = (st_reg.sts_byte_iout & ~clear_faults) | st_reg.oc_s; // R11 R2
		st_next.sts_iout_peak = (st_reg.sts_iout_peak & ~clear_faults) | st_reg.oc_s; // R11 R2
		st_next.sts_cml = st_reg.sts_cml & ~clear_faults; // R2

		// host request: held fields are stable while the toggle is pending
		if (st_reg.req_s != st_reg.req_seen) begin
			st_next.req_seen = st_reg.req_s;
			st_next.ack_tgl = ~st_reg.ack_tgl;
			if (xfer_write) begin
				case (xfer_code)
					CMD_UV_ACTION: begin
						if (uv_act_ok(xfer_wdata[7:0])) begin
							st_next.uv_act = xfer_wdata[7:0];
						end else begin
							bad = 1'b1; // R7
						end
					end
					CMD_OC_LIMIT: begin
						if (lim_ok(xfer_wdata)) begin
							st_next.oc_lim = xfer_wdata; // R8
						end else begin
							bad = 1'b1; // R9 R10
						end
					end
					CMD_OC_ACTION: begin
						if (retry_ok(xfer_wdata[RETRY_LSB +: 3])) begin
							st_next.oc_act = xfer_wdata[7:0];
						end else begin
							bad = 1'b1; // R7
						end
					end
					default: begin
					end
				endcase
			end
			case (xfer_code)
				CMD_UV_ACTION: st_next.rsp_data = {8'h00, st_next.uv_act};
				CMD_OC_LIMIT: st_next.rsp_data = st_next.oc_lim;
				CMD_OC_ACTION: st_next.rsp_data = {8'h00, st_next.oc_act};
				default: st_next.rsp_data = 16'h0000;
			endcase
		end
		if (bad) begin
			st_next.sts_cml = 1'b1; // R7
		end

		st_next.alert_n = ~(st_next.sts_word_vout | st_next.sts_word_iout
			| st_next.sts_cml); // R1 R11

		if (store_user_all) begin
			st_next.nv_wr = 1'b1; // R17
			st_next.nv_uv = st_reg.uv_act;
			st_next.nv_lim = st_reg.oc_lim;
			st_next.nv_oc = st_reg.oc_act;
		end

		// power state; overcurrent retry wins when both trip together
		unique case (st_reg.pwr)
			PWR_OFF: begin
				if (power_on_cmd) begin
					st_next.pwr = PWR_RUN;
				end
			end
			PWR_RUN: begin
				if (!power_on_cmd) begin
					st_next.pwr = PWR_OFF;
				end else if (oc_trip) begin
					st_next.pwr = (st_reg.oc_act[RETRY_LSB +: 3] == RETRY_HICCUP)
						? PWR_HICCUP : PWR_LATCH; // R5 R14 R15
				end else if (uv_trip) begin
					st_next.pwr = (st_reg.uv_act[RETRY_LSB +: 3] == RETRY_HICCUP)
						? PWR_HICCUP : PWR_LATCH; // R4 R5
				end
			end
			PWR_LATCH: begin
				if (clear_faults || !power_on_cmd) begin
					st_next.pwr = PWR_OFF; // R5
				end
			end
			PWR_HICCUP: begin
				if (!power_on_cmd) begin
					st_next.pwr = PWR_OFF;
				end else if (hic_exp) begin
					st_next.pwr = PWR_RUN; // R5
				end
			end
			default: st_next.pwr = PWR_OFF;
		endcase

		// limiting continues through codes 00, 01 and the 10 delay
		st_next.ilim = (st_next.pwr == PWR_RUN) && st_reg.oc_s
			&& (oc_code != OC_ACT_SHUT); // R12 R14
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			st_reg <= CORE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ===========================================
	// outputs
	assign output_enable = (st_reg.pwr == PWR_RUN);
	assign current_limit_on = st_reg.ilim;
	assign alert_out_n = st_reg.alert_n;
	assign status_word_vout = st_reg.sts_word_vout;
	assign status_vout_undervolt = st_reg.sts_vout_low;
	assign status_word_iout = st_reg.sts_word_iout;
	assign status_byte_iout = st_reg.sts_byte_iout;
	assign status_iout_peak = st_reg.sts_iout_peak;
	assign status_cml_invalid = st_reg.sts_cml;
	assign nv_wr_en = st_reg.nv_wr;
	assign nv_uv_action = st_reg.nv_uv;
	assign nv_oc_limit = st_reg.nv_lim;
	assign nv_oc_action = st_reg.nv_oc;

endmodule : pfr_fault_ctrl

// ==== verilog/pfr_link_port.sv ====
// pfr_link_port: host command port on the link clock, toggle handshake to core
// assumes: link_resetn synchronous to link_clk; core answers by toggling ack
module pfr_link_port (
	input wire logic link_clk, // link clock
	input wire logic link_resetn, // sync reset, active low
	input wire logic host_valid, // request present
	input wire logic host_write, // 1 write, 0 read
	input wire logic [pfr_pkg::CODE_W-1:0] host_code, // command code
	input wire logic [pfr_pkg::DATA_W-1:0] host_wdata, // write data
	output logic host_ready, // port idle
	output logic host_rsp_valid, // answer pulse
	output logic [pfr_pkg::DATA_W-1:0] host_rsp_data, // answer word
	output logic xfer_req_tgl, // toggles per request
	output logic xfer_write, // held request kind
	output logic [pfr_pkg::CODE_W-1:0] xfer_code, // held code
	output logic [pfr_pkg::DATA_W-1:0] xfer_wdata, // held data
	input wire logic xfer_ack_tgl, // core ack, core domain
	input wire logic [pfr_pkg::DATA_W-1:0] xfer_rsp_data // stable once ack toggled
);
	import pfr_pkg::*;

	typedef struct packed {
		logic busy;
		logic req_tgl;
		logic write;
		logic [CODE_W-1:0] code;
		logic [DATA_W-1:0] wdata;
		logic ack_meta;
		logic ack_s;
		logic rsp_valid;
		logic [DATA_W-1:0] rsp_data;
	} pfr_link_t;

	pfr_link_t st_reg;
	pfr_link_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.ack_meta = xfer_ack_tgl;
		st_next.ack_s = st_reg.ack_meta;
		st_next.rsp_valid = 1'b0;
		if (!st_reg.busy && host_valid) begin
			// request fields stay frozen until the ack returns
			st_next.busy = 1'b1;
			st_next.req_tgl = ~st_reg.req_tgl;
			st_next.write = host_write;
			st_next.code = host_code;
			st_next.wdata = host_wdata;
		end else if (st_reg.busy && st_reg.ack_s == st_reg.req_tgl) begin
			st_next.busy = 1'b0;
			st_next.rsp_valid = 1'b1;
			st_next.rsp_data = xfer_rsp_data;
		end
	end

	always_ff @(posedge link_clk) begin
		if (!link_resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign host_ready = ~st_reg.busy;
	assign host_rsp_valid = st_reg.rsp_valid;
	assign host_rsp_data = st_reg.rsp_data;
	assign xfer_req_tgl = st_reg.req_tgl;
	assign xfer_write = st_reg.write;
	assign xfer_code = st_reg.code;
	assign xfer_wdata = st_reg.wdata;

endmodule : pfr_link_port

// ==== verilog/pfr_pkg.sv ====
// pfr_pkg: constants and types shared by the fault response block
// assumes: core clock period as given below; all other files but the checker import this
package pfr_pkg;

	// ===========================================
	// widths and clock
	localparam int CLK_PERIOD_NS = 20;
	localparam int CODE_W = 8;
	localparam int DATA_W = 16;
	localparam int TMR_W = 26;

	// ===========================================
	// command codes and reset values
	localparam logic [7:0] CMD_UV_ACTION = 8'h45;
	localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
	localparam logic [7:0] CMD_OC_ACTION = 8'h47;
	localparam logic [7:0] RST_UV_ACTION = 8'h40;
	localparam logic [15:0] RST_OC_LIMIT = 16'h081B;
	localparam logic [7:0] RST_OC_ACTION = 8'h80;

	// ===========================================
	// field layout and encodings
	localparam int ACT_LSB = 6;
	localparam int RETRY_LSB = 3;
	localparam int UV_DLY_LSB = 0;
	localparam int OC_DLY_LSB = 0;
	localparam int LIM_EXP_LSB = 11;
	localparam logic [1:0] UV_ACT_IGNORE = 2'h0;
	localparam logic [1:0] UV_ACT_DELAY = 2'h1;
	localparam logic [1:0] OC_ACT_LIMIT = 2'h0;
	localparam logic [1:0] OC_ACT_RUN = 2'h1;
	localparam logic [1:0] OC_ACT_DELAY = 2'h2;
	localparam logic [1:0] OC_ACT_SHUT = 2'h3;
	localparam logic [2:0] RETRY_LATCH = 3'h0;
	localparam logic [2:0] RETRY_HICCUP = 3'h7;
	localparam logic [4:0] LIM_EXP = 5'h01;
	localparam logic [10:0] LIM_MANT_MIN = 11'h001;
	localparam logic [10:0] LIM_MANT_MAX = 11'h01F;

	// ===========================================
	// timing
	localparam int UV_DLY0_NS = 6250;
	localparam int UV_DLY1_NS = 7500;
	localparam int UV_DLY2_NS = 8750;
	localparam int UV_DLY3_NS = 10000;
	localparam logic [TMR_W-1:0] UV_DLY0_CYC = TMR_W'((UV_DLY0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] UV_DLY1_CYC = TMR_W'((UV_DLY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] UV_DLY2_CYC = TMR_W'((UV_DLY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] UV_DLY3_CYC = TMR_W'((UV_DLY3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// overcurrent windows are multiples of a 160 us step: 1 2 4 8 16 32 60 63
	localparam int OC_BASE_NS = 160000;
	localparam logic [TMR_W-1:0] OC_BASE_CYC_DFLT = TMR_W'((OC_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [5:0] OC_MULT0 = 6'h01;
	localparam logic [5:0] OC_MULT1 = 6'h02;
	localparam logic [5:0] OC_MULT2 = 6'h04;
	localparam logic [5:0] OC_MULT3 = 6'h08;
	localparam logic [5:0] OC_MULT4 = 6'h10;
	localparam logic [5:0] OC_MULT5 = 6'h20;
	localparam logic [5:0] OC_MULT6 = 6'h3C;
	localparam logic [5:0] OC_MULT7 = 6'h3F;
	localparam int HICCUP_NS = 1000000000;
	localparam logic [TMR_W-1:0] HICCUP_CYC_DFLT = TMR_W'(HICCUP_NS / CLK_PERIOD_NS);

	// ===========================================
	// power state
	typedef enum logic [3:0] {
		PWR_OFF = 4'h1,
		PWR_RUN = 4'h2,
		PWR_LATCH = 4'h4,
		PWR_HICCUP = 4'h8
	} pfr_pwr_t;

endpackage : pfr_pkg
